//--- verilog/icb_core.sv
// Purpose: I2C master sequencer with collision checks and AHB registers
// Assumes: pins are open drain, inputs synchronous to clk
// Notes:   one baud counter serves I2C and SPI master clocking
`timescale 1ns/10ps
module icb_core import icb_pkg::*; #(
  parameter int RELOAD_W = 8
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // I2C bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             sda_out,
  output logic             sda_oe,
  // SPI master clock
  output logic             spi_sck,
  // Event and option levels
  output logic             collision_irq_flag,
  output logic             port_irq_flag,
  output logic             slew_rate_off,
  output logic             smbus_levels,
  output logic             spi_sample_late,
  output logic             spi_shift_to_idle
);

  // Whole state of the block
  typedef struct packed {
    icb_seq_e   st;      // Sequencer state
    icb_job_e   job;     // Bit engine job
    logic       wr;      // Write data phase pending
    logic [7:0] waddr;   // Address of pending write
    logic       ready;   // Bus ready
    logic [31:0] rdata;  // Read data
    logic [7:0] reload;  // Baud reload value
    logic [7:0] buff;    // Shift buffer
    logic [7:0] mask;    // Address mask
    logic [7:0] c1;      // Control one
    logic [7:0] c2;      // Control two
    logic [7:0] c3;      // Control three
    logic [7:0] stat;    // Port status
    logic       bcl;     // Collision flag
    logic       pif;     // Port event flag
    logic       txgo;    // Buffer written, transfer pending
    logic       addr_nx; // Next byte is an address
    logic [8:0] shreg;   // Outgoing bits
    logic [7:0] rxsh;    // Incoming bits
    logic [4:0] bits;    // Bits or edges left
    logic       sck;     // SPI clock level
    icb_pins_s  pins;    // Pin drive
    logic       slew;    // Slew control off
    logic       smb;     // SMBus input levels
    logic       late;    // SPI late sample
    logic       edge_sel;// SPI shift edge
  } icb_state_s;

  icb_state_s s;
  icb_state_s next_s;
  logic [1:0] rst_pipe;  // Reset release synchroniser
  logic       rst_n;     // Synchronised reset
  logic       brg_load;  // Reload request to the counter
  logic       brg_run;   // Counter runs
  logic       brg_exp;   // Half period elapsed
  logic       take;      // Address phase accepted

  // Reset released through two flops, asserted at once
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Mode is one of the I2C modes
  function automatic logic is_i2c(input logic [3:0] m);
    is_i2c = (m[3:1] == 3'b011) || (m == 4'h8) || (m == 4'hb) ||
             (m[3:1] == 3'b111);
  endfunction

  // Register read decode
  function automatic logic [7:0] reg_read(input logic [7:0] a,
                                          input icb_state_s x);
    if (a == OFF_RELOAD) begin
      reg_read = x.reload;
    end else if (a == OFF_BUFFER) begin
      reg_read = x.buff;
    end else if (a == OFF_CTRL1) begin
      reg_read = x.c1;
    end else if (a == OFF_CTRL2) begin
      reg_read = x.c2;
    end else if (a == OFF_CTRL3) begin
      reg_read = x.c3;
    end else if (a == OFF_MASK) begin
      reg_read = x.mask;
    end else if (a == OFF_STATUS) begin
      reg_read = x.stat;
    end else if (a == OFF_FLAGS) begin
      reg_read = {6'h00, x.pif, x.bcl};
    end else begin
      reg_read = 8'h00; // Unmapped reads as zero
    end
  endfunction

  // Abort on collision: flag, release lines, clear sequence bits
  function automatic icb_state_s abort(input icb_state_s x);
    abort             = x;
    abort.bcl         = 1'b1;         // see RULE23
    abort.st          = SQ_IDLE;      // see RULE23
    abort.pins.scl_oe = 1'b0;         // see RULE24
    abort.pins.sda_oe = 1'b0;         // see RULE24
    abort.c2          = x.c2 & ~C2_SEQ_MASK; // see RULE24
    abort.stat[ST_RW] = 1'b0;
    abort.stat[ST_BF] = 1'b0;
    abort.txgo        = 1'b0;
  endfunction

  // Shared baud counter for I2C and SPI (see RULE10)
  icb_baud #(
    .WIDTH (RELOAD_W)
  ) u_baud (
    .clk    (clk),
    .rst_n  (rst_n),
    .load   (brg_load),
    .run    (brg_run),
    .reload (s.reload[RELOAD_W-1:0]),
    .expire (brg_exp)
  );

  assign take = hsel && htrans[1] && hready;

  // Next state: bus access first, sequencer after, so hardware sets win
  always_comb begin
    next_s   = s;
    brg_load = 1'b0;
    brg_run  = (s.st != SQ_IDLE); // Stops once done (see RULE12)
    next_s.wr = 1'b0;

    // Address phase: capture read data, remember write
    if (take) begin
      next_s.waddr = haddr[7:0];
      next_s.wr    = hwrite;
      if (!hwrite) begin
        next_s.rdata = {24'h000000, reg_read(haddr[7:0], s)};
        if (haddr[7:0] == OFF_BUFFER) begin
          next_s.stat[ST_BF] = 1'b0; // Reading empties the buffer
        end
      end
    end

    // Data phase of a write
    if (s.wr) begin
      if (s.waddr == OFF_RELOAD) begin
        next_s.reload = hwdata[7:0]; // 0..2 unsupported (see RULE15)
      end else if (s.waddr == OFF_BUFFER) begin
        if (s.st != SQ_IDLE) begin
          next_s.c1[C1_WCOL] = 1'b1; // Busy: write dropped
        end else begin
          next_s.buff = hwdata[7:0];
          next_s.txgo = 1'b1; // Counter starts next cycle (see RULE11)
          next_s.stat[ST_BF] = 1'b1;
        end
      end else if (s.waddr == OFF_CTRL1) begin
        // Two top bits clear only
        next_s.c1 = {s.c1[7:6] & hwdata[7:6], hwdata[5:0]};
      end else if (s.waddr == OFF_CTRL2) begin
        next_s.c2[7] = hwdata[7];
        next_s.c2[C2_ACKDT] = hwdata[C2_ACKDT];
        // No queuing of sequences while busy
        if (s.st == SQ_IDLE && !s.txgo) begin
          next_s.c2[4:0] = hwdata[4:0];
        end
      end else if (s.waddr == OFF_CTRL3) begin
        next_s.c3 = hwdata[7:0];
      end else if (s.waddr == OFF_MASK) begin
        next_s.mask = hwdata[7:0];
      end else if (s.waddr == OFF_STATUS) begin
        next_s.stat[7:6] = hwdata[7:6]; // Only option bits writable
      end else if (s.waddr == OFF_FLAGS) begin
        next_s.bcl = s.bcl & hwdata[FL_BCL]; // Write zero clears
        next_s.pif = s.pif & hwdata[FL_IF];
      end
    end

    // Sequencer
    case (s.st)
      SQ_IDLE: begin
        if (s.c1[3:0] == MODE_I2C_MST && s.c1[C1_EN]) begin
          if (s.c2[C2_SEN]) begin
            if (!sda_in || !scl_in) begin
              next_s = abort(next_s);
            end else begin
              brg_load = 1'b1;
              next_s.st = SQ_S_HOLD;
            end
          end else if (s.c2[C2_RESTART_SEQ_ENABLE]) begin
            next_s.pins.sda_oe = 1'b0; // Let SDA float (see RULE3)
            next_s.pins.scl_oe = 1'b1;
            brg_load = 1'b1;
            next_s.st = SQ_RS_REL;
          end else if (s.c2[C2_PEN]) begin
            next_s.pins.sda_oe = 1'b1; // Stop opens with SDA low (see RULE9)
            next_s.pins.scl_oe = 1'b1;
            next_s.st = SQ_P_LOW;
          end else if (s.c2[C2_RECEIVE_SEQ_ENABLE] || s.c2[C2_ACK_SEQ_ENABLE] || s.txgo) begin
            next_s.job = s.txgo ? JOB_TX :
                         (s.c2[C2_RECEIVE_SEQ_ENABLE] ? JOB_RX : JOB_ACK);
            next_s.shreg = s.txgo ? {s.buff, 1'b1} :
                           {s.c2[C2_ACKDT] | s.c2[C2_RECEIVE_SEQ_ENABLE], 8'hff};
            next_s.bits = s.txgo ? BITS_TX :
                          (s.c2[C2_RECEIVE_SEQ_ENABLE] ? BITS_RX : BITS_ACK);
            next_s.stat[ST_RW] = s.txgo; // Reads one in transmit (see RULE22)
            next_s.txgo = 1'b0;
            next_s.pins.scl_oe = 1'b1;
            brg_load = 1'b1; // see RULE11
            next_s.st = SQ_B_LOW;
          end
        end else if (s.c1[3:0] == MODE_SPI_MST && s.txgo) begin
          // SPI master byte clocked by the same counter (see RULE10)
          next_s.txgo = 1'b0;
          next_s.sck  = s.c1[C1_CKP];
          next_s.bits = SPI_EDGES;
          brg_load    = 1'b1; // see RULE11
          next_s.st   = SQ_SPI;
        end
      end

      SQ_S_HOLD: begin
        if (!scl_in) begin
          next_s = abort(next_s); // Clock low before our SDA
        end else if (!sda_in || brg_exp) begin
          // Early SDA fall restarts the count and asserts at once
          next_s.pins.sda_oe = 1'b1;
          brg_load = 1'b1;
          next_s.st = SQ_S_LOW;
        end
      end

      SQ_S_LOW, SQ_RS_LOW: begin
        if (brg_exp) begin
          // Clock low whatever its level (see RULE6)
          next_s.pins.scl_oe = 1'b1;
          next_s.c2[C2_SEN]  = 1'b0;
          next_s.c2[C2_RESTART_SEQ_ENABLE] = 1'b0;
          next_s.stat[ST_S]  = 1'b1; // see RULE21
          next_s.stat[ST_P]  = 1'b0; // see RULE20
          next_s.addr_nx = 1'b1;
          next_s.pif = 1'b1;
          next_s.st = SQ_IDLE;
        end
      end

      SQ_RS_REL: begin
        if (brg_exp) begin
          next_s.pins.scl_oe = 1'b0; // Release SCL after count (see RULE3)
          next_s.st = SQ_RS_HIGH;
        end
      end

      SQ_RS_HIGH: begin
        if (scl_in) begin
          if (!sda_in) begin
            next_s = abort(next_s); // SDA low at SCL rise (see RULE1)
          end else begin
            brg_load = 1'b1; // SDA high: count again (see RULE4)
            next_s.st = SQ_RS_CHK;
          end
        end
      end

      SQ_RS_CHK: begin
        if (!sda_in) begin
          // Another master's SDA fall is no collision (see RULE4)
          next_s.pins.sda_oe = 1'b1;
          brg_load = 1'b1;
          next_s.st = SQ_RS_LOW;
        end else if (!scl_in) begin
          next_s = abort(next_s); // SCL fell first (see RULE2) (see RULE5)
        end else if (brg_exp) begin
          next_s.pins.sda_oe = 1'b1; // Both high: SDA low (see RULE6)
          brg_load = 1'b1;
          next_s.st = SQ_RS_LOW;
        end
      end

      SQ_P_LOW: begin
        if (!sda_in) begin
          next_s.pins.scl_oe = 1'b0; // SDA low seen: free SCL (see RULE9)
          next_s.st = SQ_P_REL;
        end
      end

      SQ_P_REL: begin
        if (scl_in) begin
          brg_load = 1'b1; // Clock arbitration passed (see RULE9)
          next_s.st = SQ_P_CNT;
        end
      end

      SQ_P_CNT: begin
        if (!scl_in) begin
          next_s = abort(next_s); // see RULE8
        end else if (brg_exp) begin
          next_s.pins.sda_oe = 1'b0;
          brg_load = 1'b1;
          next_s.st = SQ_P_SDA;
        end
      end

      SQ_P_SDA: begin
        if (!scl_in && !sda_in) begin
          next_s = abort(next_s); // SCL low before SDA high (see RULE8)
        end else if (brg_exp) begin
          if (!sda_in) begin
            next_s = abort(next_s); // SDA held low (see RULE7)
          end else begin
            next_s.stat[ST_P] = 1'b1; // see RULE20
            next_s.stat[ST_S] = 1'b0; // see RULE21
            brg_load = 1'b1;
            next_s.st = SQ_P_END;
          end
        end
      end

      SQ_P_END: begin
        if (brg_exp) begin
          next_s.c2[C2_PEN] = 1'b0;
          next_s.pif = 1'b1;
          next_s.st = SQ_IDLE;
        end
      end

      SQ_B_LOW: begin
        next_s.pins.sda_oe = ~s.shreg[8]; // Zero pulls SDA low
        if (brg_exp) begin
          next_s.pins.scl_oe = 1'b0;
          next_s.st = SQ_B_HIGH;
        end
      end

      SQ_B_HIGH: begin
        if (scl_in) begin
          brg_load = 1'b1; // Stretch until SCL really high
          next_s.st = SQ_B_CNT;
        end
      end

      SQ_B_CNT: begin
        if (brg_exp) begin
          next_s.pins.scl_oe = 1'b1;
          next_s.rxsh  = {s.rxsh[6:0], sda_in};
          next_s.shreg = {s.shreg[7:0], 1'b1};
          next_s.bits  = s.bits - 1'b1;
          brg_load = 1'b1;
          next_s.st = SQ_B_LOW;
          if (s.bits == 5'h01) begin
            next_s.st = SQ_IDLE;
            next_s.pif = 1'b1;
            next_s.pins.sda_oe = 1'b0;
            if (s.job == JOB_TX) begin
              next_s.c2[C2_ACKSTAT] = sda_in;
              next_s.stat[ST_BF] = 1'b0;
              next_s.stat[ST_RW] = 1'b0; // see RULE22
              next_s.stat[ST_DA] = ~s.addr_nx; // see RULE19
              next_s.addr_nx = 1'b0;
            end else if (s.job == JOB_RX) begin
              next_s.buff = {s.rxsh[6:0], sda_in};
              next_s.stat[ST_BF] = 1'b1;
              next_s.stat[ST_DA] = 1'b1; // see RULE19
              next_s.c2[C2_RECEIVE_SEQ_ENABLE] = 1'b0;
            end else begin
              next_s.c2[C2_ACK_SEQ_ENABLE] = 1'b0;
            end
          end
        end
      end

      SQ_SPI: begin
        if (brg_exp) begin
          next_s.sck  = ~s.sck;
          next_s.bits = s.bits - 1'b1;
          if (s.bits == 5'h01) begin
            next_s.pif = 1'b1;
            next_s.st  = SQ_IDLE; // Clock stays at last level
          end
        end
      end

      default: begin
        next_s.st = SQ_IDLE;
      end
    endcase

    // Disabled port: idle, lines free, start and stop bits clear
    if (!s.c1[C1_EN] || (s.st != SQ_IDLE && s.st != SQ_SPI &&
        s.c1[3:0] != MODE_I2C_MST)) begin
      next_s.st = SQ_IDLE; // Checks only when enabled master (see RULE25)
      next_s.pins.scl_oe = 1'b0;
      next_s.pins.sda_oe = 1'b0;
      next_s.c2 = next_s.c2 & ~C2_SEQ_MASK;
      if (!s.c1[C1_EN]) begin
        next_s.stat[ST_P] = 1'b0; // see RULE20
        next_s.stat[ST_S] = 1'b0; // see RULE21
      end
    end

    // Option levels registered for the pads and SPI path
    next_s.slew = is_i2c(next_s.c1[3:0]) & next_s.stat[ST_SMP]; // see RULE17
    next_s.smb  = is_i2c(next_s.c1[3:0]) & next_s.stat[ST_CKE]; // see RULE18
    next_s.late = (next_s.c1[3:0] == MODE_SPI_MST) &
                  next_s.stat[ST_SMP]; // see RULE16
    next_s.edge_sel = ~is_i2c(next_s.c1[3:0]) &
                      next_s.stat[ST_CKE]; // see RULE18
    next_s.pins.scl_out = 1'b0;
    next_s.pins.sda_out = 1'b0;
    next_s.ready = 1'b1;
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s       <= '0;
      s.st    <= SQ_IDLE;
      s.job   <= JOB_TX;
      s.ready <= 1'b1;
      s.stat  <= RST_STATUS;
      s.c1    <= RST_REG;
      s.c2    <= RST_REG;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register, except hresp tied low
  assign hreadyout          = s.ready;
  assign hrdata             = s.rdata;
  assign hresp              = 1'b0;
  assign scl_out            = s.pins.scl_out;
  assign scl_oe             = s.pins.scl_oe;
  assign sda_out            = s.pins.sda_out;
  assign sda_oe             = s.pins.sda_oe;
  assign spi_sck            = s.sck;
  assign collision_irq_flag = s.bcl;
  assign port_irq_flag      = s.pif;
  assign slew_rate_off      = s.slew;
  assign smbus_levels       = s.smb;
  assign spi_sample_late    = s.late;
  assign spi_shift_to_idle  = s.edge_sel;

endmodule

//--- verilog/icb_pkg.sv
// Purpose: shared constants and types of the I2C master collision block
// Assumes: 25 MHz system clock, AHB-Lite register access, one master port
// Notes:   register offsets are byte addresses of aligned 32-bit words
// Behaviour
// RULE1: Restart: SDA low at SCL rise is collision
// RULE2: Restart: SCL falls before our SDA low
// RULE3: Restart: release SDA, count, release SCL
// RULE4: Restart: SDA high reloads; early SDA fall fine
// RULE5: Restart: SCL fall before expiry is collision
// RULE6: Restart: both high, drive SDA, then SCL
// RULE7: Stop: SDA low after count is collision
// RULE8: Stop: SCL low before SDA high collides
// RULE9: Stop: SDA low, release SCL, count, sample
// RULE10: One baud counter for I2C and SPI
// RULE11: Buffer write starts the baud counter
// RULE12: Operation done stops counter, SCL holds
// RULE13: Counter reloads twice per SCL period
// RULE14: SCL rate is clock over 4(N+1)
// RULE15: Software avoids reload values 0, 1, 2
// RULE16: SPI: sample-phase bit picks sample point
// RULE17: I2C: sample-phase bit disables slew control
// RULE18: Clock-edge bit: SPI edge or SMBus levels
// RULE19: Data-not-address bit follows last byte
// RULE20: Stop-seen bit, cleared by reset, disable
// RULE21: Start-seen bit, cleared by reset, disable
// RULE22: Direction bit reads one while transmitting
// RULE23: Collision sets flag, port returns idle
// RULE24: Collision aborts sequence, releases lines
// RULE25: Checks only in enabled master sequences
package icb_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_RELOAD = 8'h00;
  localparam logic [7:0] OFF_BUFFER = 8'h04;
  localparam logic [7:0] OFF_CTRL1  = 8'h08;
  localparam logic [7:0] OFF_CTRL2  = 8'h0c;
  localparam logic [7:0] OFF_CTRL3  = 8'h10;
  localparam logic [7:0] OFF_MASK   = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_FLAGS  = 8'h1c;

  // Reset values
  localparam logic [7:0] RST_REG    = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;

  // Status field positions
  localparam int ST_SMP = 7;
  localparam int ST_CKE = 6;
  localparam int ST_DA  = 5;
  localparam int ST_P   = 4;
  localparam int ST_S   = 3;
  localparam int ST_RW  = 2;
  localparam int ST_BF  = 0;

  // Control one fields
  localparam int C1_WCOL = 7;
  localparam int C1_EN   = 5;
  localparam int C1_CKP  = 4;

  // Control two fields
  localparam int C2_ACKSTAT = 6;
  localparam int C2_ACKDT   = 5;
  localparam int C2_ACK_SEQ_ENABLE   = 4;
  localparam int C2_RECEIVE_SEQ_ENABLE    = 3;
  localparam int C2_PEN     = 2;
  localparam int C2_RESTART_SEQ_ENABLE    = 1;
  localparam int C2_SEN     = 0;
  localparam logic [7:0] C2_SEQ_MASK = 8'h1f;

  // Flags register fields
  localparam int FL_BCL = 0;
  localparam int FL_IF  = 1;

  // Mode codes
  localparam logic [3:0] MODE_I2C_MST = 4'h8;
  localparam logic [3:0] MODE_SPI_MST = 4'ha;

  // Baud timing: counter steps once every two system clocks
  localparam int OSC_PER_TICK = 2;
  localparam int PRE_W        = 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(OSC_PER_TICK - 1);

  // Sequence lengths
  localparam logic [4:0] BITS_TX   = 5'h09;
  localparam logic [4:0] BITS_RX   = 5'h08;
  localparam logic [4:0] BITS_ACK  = 5'h01;
  localparam logic [4:0] SPI_EDGES = 5'h10;

  // Sequencer states
  typedef enum logic [4:0] {
    SQ_IDLE, SQ_S_HOLD, SQ_S_LOW,
    SQ_RS_REL, SQ_RS_HIGH, SQ_RS_CHK, SQ_RS_LOW,
    SQ_P_LOW, SQ_P_REL, SQ_P_CNT, SQ_P_SDA, SQ_P_END,
    SQ_B_LOW, SQ_B_HIGH, SQ_B_CNT, SQ_SPI
  } icb_seq_e;

  // Bit engine jobs
  typedef enum logic [1:0] {JOB_TX, JOB_RX, JOB_ACK} icb_job_e;

  // Open-drain pin drive, carried together
  typedef struct packed {
    logic scl_oe;
    logic scl_out;
    logic sda_oe;
    logic sda_out;
  } icb_pins_s;

endpackage

//--- verilog/icb_baud.sv
// Purpose: reloadable baud counter with prescale enable
// Assumes: reload value stays stable while the counter runs
// Notes:   expire is a one-cycle pulse, one per half SCL period
`timescale 1ns/10ps
module icb_baud import icb_pkg::*; #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             load,
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] reload,
  // Rollover pulse
  output logic                  expire
);

  // Whole state of the counter
  typedef struct packed {
    logic [PRE_W-1:0] pre;    // Prescale phase
    logic [WIDTH-1:0] cnt;    // Down counter
    logic             expire; // Rollover pulse
  } icb_baud_s;

  icb_baud_s s;
  icb_baud_s next_s;

  // Count down on each prescale enable, reload on rollover
  always_comb begin
    next_s        = s;
    next_s.expire = 1'b0;
    if (load) begin
      // Fresh half period, taken from idle too so the first one is full
      next_s.cnt = reload;
      next_s.pre = '0;
    end else if (!run) begin
      // Stopped: count frozen, SCL holds its level (see RULE12)
      next_s.pre = '0;
    end else if (s.pre == PRE_LAST) begin
      // One count per two clocks gives clk/(4(N+1)) (see RULE14)
      next_s.pre = '0;
      if (s.cnt == '0) begin
        next_s.expire = 1'b1;
        next_s.cnt    = reload; // Two reloads per period (see RULE13)
      end else begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end else begin
      next_s.pre = s.pre + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign expire = s.expire;

endmodule

//--- test/icb_chk.sv
// Purpose: port-level checks of icb_core
// Assumes: open-drain pins, one clock domain
// Notes:   bound to every icb_core instance below
`timescale 1ns/10ps
module icb_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Register bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Bus lines
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  // Flags and options
  input wire logic        collision_irq_flag,
  input wire logic        slew_rate_off,
  input wire logic        smbus_levels,
  input wire logic        spi_sample_late,
  input wire logic        spi_shift_to_idle
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic rd_prev; // Read taken at last edge
  // Track accepted reads so hrdata may only move after one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rd_prev <= 1'b0;
    else rd_prev <= hsel & htrans[1] & hready & !hwrite;
  end
  sequence s_coll; $rose(collision_irq_flag); endsequence
  sequence s_sda_first; $rose(sda_oe) && !scl_oe; endsequence
  property p_okay; hreadyout && !hresp && hrdata[31:8] == 24'h0;
  endproperty
  property p_drain; !scl_out && !sda_out; endproperty
  property p_abort; s_coll |-> (!scl_oe && !sda_oe) [*2]; endproperty
  property p_cause; s_coll |-> !$past(sda_in) || !$past(scl_in)
    || !$past(sda_in, 2) || !$past(scl_in, 2); endproperty
  property p_seq; s_sda_first |-> ##[1:1000] (scl_oe || !sda_oe);
  endproperty
  property p_hold; !rd_prev |-> $stable(hrdata); endproperty
  property p_slew; !(slew_rate_off && spi_sample_late); endproperty
  property p_edge; !(smbus_levels && spi_shift_to_idle); endproperty
  a_okay: assert property (p_okay)
    else $error("bus answer not okay");
  a_drain: assert property (p_drain)
    else $error("pin driven high");
  a_abort: assert property (p_abort)
    else $error("lines held after collision");
  a_cause: assert property (p_cause)
    else $error("collision with both lines high");
  a_seq: assert property (p_seq)
    else $error("clock not pulled after data");
  a_hold: assert property (p_hold)
    else $error("read data moved without read");
  a_slew: assert property (p_slew)
    else $error("status bit7 in two modes");
  a_edge: assert property (p_edge)
    else $error("status bit6 in two modes");
endmodule
bind icb_core icb_chk icb_chk_i (.clk, .nrst, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hrdata, .hresp, .scl_in, .sda_in, .scl_out,
  .scl_oe, .sda_out, .sda_oe, .collision_irq_flag, .slew_rate_off,
  .smbus_levels, .spi_sample_late, .spi_shift_to_idle);

//--- test/icb_bus.sv
// Purpose: shared I2C wires with pull-ups and a rival master
// Assumes: rival only pulls data low when the bench says so
// Notes:   released lines float high through the pull-ups
`timescale 1ns/10ps
module icb_bus (
  // Device drive
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Rival master command
  input wire logic hold_sda,
  // Wire levels
  output logic     scl_in,
  output logic     sda_in
);
  // Wired-and: any pull wins over the pull-up
  assign scl_in = !scl_oe;
  assign sda_in = !(sda_oe || hold_sda);
endmodule

//--- test/i2c_master_collision_brg_tb_top.sv
// Purpose: self-checking bench of icb_core
// Assumes: reload 3, so a half period is about 8 clocks
// Notes:   rival master forces the collision cases
`timescale 1ns/10ps
module i2c_master_collision_brg_tb_top;
  import icb_pkg::*;
  logic clk, nrst, hsel, hwrite, hold_sda, hreadyout, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic scl_in, sda_in, scl_oe, sda_oe, spi_sck, coll, pif;
  logic slew, smb, sml, shi;
  logic [7:0] rd; // Last read byte
  int n_fail, total_checks, cyc, n;
  icb_core icb_core_i (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
    .hresp, .scl_in, .sda_in, .scl_out(), .scl_oe, .sda_out(), .sda_oe,
    .spi_sck, .collision_irq_flag(coll), .port_irq_flag(pif),
    .slew_rate_off(slew), .smbus_levels(smb), .spi_sample_late(sml),
    .spi_shift_to_idle(shi));
  icb_bus icb_bus_i (.scl_oe, .sda_oe, .hold_sda, .scl_in, .sda_in);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      give_verdict;
    end
  end
  task give_verdict;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One single AHB transfer, read byte lands in rd
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask
  // Poll until no sequence bit is left
  task idle;
    repeat (400) begin
      xfer(1'b0, OFF_CTRL2, 8'h00);
      if (rd[4:0] === 5'h00) return;
    end
  endtask
  task t_reset;
    xfer(1'b0, OFF_STATUS, 8'h00); chk(rd, RST_STATUS);
    xfer(1'b0, OFF_RELOAD, 8'h00); chk(rd, RST_REG);
    xfer(1'b0, 8'h24, 8'h00); chk(rd, 8'h00);
  endtask
  task seq(input logic [7:0] c, input logic [7:0] st);
    xfer(1'b1, OFF_CTRL2, c); idle; chk(rd & C2_SEQ_MASK, 8'h00);
    xfer(1'b0, OFF_STATUS, 8'h00); chk(rd & 8'h18, st);
  endtask
  task t_clean;
    xfer(1'b1, OFF_RELOAD, 8'h03);
    xfer(1'b1, OFF_CTRL1, 8'h28);
    seq(8'h01, 8'h08);
    seq(8'h02, 8'h08);
    chk({6'h0, scl_oe, sda_oe}, 8'h03);
    seq(8'h04, 8'h10);
    chk({6'h0, scl_oe, sda_oe}, 8'h00);
    xfer(1'b0, OFF_FLAGS, 8'h00); chk(rd, 8'h02);
    xfer(1'b1, OFF_CTRL1, 8'h08);
    xfer(1'b0, OFF_STATUS, 8'h00); chk(rd & 8'h18, 8'h00);
    xfer(1'b1, OFF_CTRL1, 8'h28);
  endtask
  // Rival holds data low through the sequence
  task t_coll(input logic [7:0] c);
    xfer(1'b1, OFF_FLAGS, 8'h00);
    hold_sda <= 1'b1;
    xfer(1'b1, OFF_CTRL2, c); idle; chk(rd & C2_SEQ_MASK, 8'h00);
    hold_sda <= 1'b0;
    xfer(1'b0, OFF_FLAGS, 8'h00); chk(rd & 8'h01, 8'h01);
    chk({5'h0, coll, scl_oe, sda_oe}, 8'h04);
  endtask
  task t_opts;
    xfer(1'b1, OFF_STATUS, 8'hc0); repeat (2) @(posedge clk);
    chk({4'h0, slew, smb, sml, shi}, 8'h0c);
    xfer(1'b1, OFF_FLAGS, 8'h00);
    xfer(1'b1, OFF_CTRL1, 8'h2a); repeat (2) @(posedge clk);
    chk({4'h0, slew, smb, sml, shi}, 8'h03);
    xfer(1'b1, OFF_BUFFER, 8'h5a);
    n = 0;
    while (pif !== 1'b1 && n < 2000) begin
      @(posedge clk); n++;
    end
    // 16 half periods of 2*(3+1) clocks, plus load latency
    chk(8'(n >= 128 && n <= 170), 8'h01);
    chk({7'h0, spi_sck}, 8'h00);
  endtask
  initial begin
    nrst = 1'b0; hsel = 1'b0; htrans = 2'h0; haddr = 32'h0;
    hwrite = 1'b0; hwdata = 32'h0; hold_sda = 1'b0;
    n_fail = 0; total_checks = 0; cyc = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset; t_clean; t_coll(8'h02); t_coll(8'h04); t_opts;
    give_verdict;
  end
endmodule
